// [rtl/i2csr_regs.svh]
/*
 * Constants of the register access engine behind the two-wire slave port:
 * address, command codes, command field positions and sequence counts.
 * Assumes it is included by bare name from the engine.
 */
`ifndef I2CSR_REGS_SVH
`define I2CSR_REGS_SVH

// Slave address: fixed upper bits, the low three come from the straps
`define I2CSR_ADDR_FIXED 4'hd
// Command codes in command byte 0
`define I2CSR_OP_WRITE 3'h3
`define I2CSR_OP_READ 3'h4
// Command field positions
`define I2CSR_C0_OP 2:0
`define I2CSR_C1_PORT 3:0
`define I2CSR_C2_PORT0 7
`define I2CSR_C2_BE 5:2
`define I2CSR_C2_AHI 1:0
`define I2CSR_ADDR_LO 2'h0
// Byte sequence within a packet
`define I2CSR_IDX_CMD_LAST 4'h3
`define I2CSR_IDX_DATA_LAST 4'h7
`define I2CSR_IDX_END 4'h8
`define I2CSR_IDX_FIRST 4'h0
`define I2CSR_BIT_LAST 3'h7
`define I2CSR_BIT_FIRST 3'h0
`define I2CSR_RD_FIRST 2'h3
// Number of ports in the switch
`define I2CSR_NUM_PORTS 5'h03
// Reset values
`define I2CSR_ZERO_WORD 32'h0000_0000
`define I2CSR_ZERO_BYTE 8'h00

`endif

// [rtl/i2csr_pkg.sv]
/*
 * Types shared by the register access engine and its bench.
 * Assumes the constants header is on the include path.
 */
package i2csr_pkg;

	// Access to the switch configuration space, issued once per command
	typedef struct packed {
		logic [4:0] port;
		logic [11:0] addr;
		logic [3:0] be;
		logic [31:0] wdata;
	} i2csr_req_t;

	// Serial engine states
	typedef enum logic [2:0] {
		I2CSR_IDLE,
		I2CSR_RX,
		I2CSR_ACK,
		I2CSR_TX,
		I2CSR_MACK
	} i2csr_state_t;

endpackage : i2csr_pkg

// [rtl/i2csr_engine.sv]
/*
 * Two-wire slave register access engine: decodes write and read command
 * packets and issues single accesses to the switch configuration space.
 * Assumes scl and sda come from pins (synchronised here), the bus runs far
 * below ref_clk, and reg_rdata is valid the cycle after a reg_rd pulse.
 */
`include "i2csr_regs.svh"

module i2csr_engine (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic scl_pin,
	input wire logic sda_pin,
	output logic sda_drv,
	output logic sda_oe,
	input wire logic [2:0] addr_strap,
	output i2csr_pkg::i2csr_req_t reg_req,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [31:0] reg_rdata
);

	// ****************************************************************
	// Pin synchronisers and bus conditions
	// ****************************************************************
	logic scl_meta, scl_s, scl_d;
	logic sda_meta, sda_s, sda_d;
	logic [2:0] strap_meta, strap_s;
	logic scl_rise, scl_fall, bus_start, bus_stop;

	// Two flops per pin, straps too, plus a third on scl and sda; stages two and three feed the logic
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			scl_meta <= 1'h1;
			scl_s <= 1'h1;
			scl_d <= 1'h1;
			sda_meta <= 1'h1;
			sda_s <= 1'h1;
			sda_d <= 1'h1;
			strap_meta <= 3'h0;
			strap_s <= 3'h0;
		end else begin
			scl_meta <= scl_pin;
			scl_s <= scl_meta;
			scl_d <= scl_s;
			sda_meta <= sda_pin;
			sda_s <= sda_meta;
			sda_d <= sda_s;
			strap_meta <= addr_strap;
			strap_s <= strap_meta;
		end
	end

	// START and STOP are sda edges while scl stays high
	assign scl_rise = scl_s & ~scl_d;
	assign scl_fall = ~scl_s & scl_d;
	assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
	assign bus_stop = scl_s & scl_d & ~sda_d & sda_s;

	// ****************************************************************
	// Command decode
	// ****************************************************************
	// Shared by the read and write paths
	function automatic i2csr_pkg::i2csr_req_t decode_cmd(
		input logic [7:0] c1,
		input logic [7:0] c2,
		input logic [7:0] c3,
		input logic [31:0] data
	);
		i2csr_pkg::i2csr_req_t r;
		r.port = {c1[`I2CSR_C1_PORT], c2[`I2CSR_C2_PORT0]};
		r.addr = {c2[`I2CSR_C2_AHI], c3, `I2CSR_ADDR_LO};
		r.be = c2[`I2CSR_C2_BE];
		r.wdata = data;
		return r;
	endfunction : decode_cmd

	// ****************************************************************
	// Serial byte engine
	// ****************************************************************
	i2csr_pkg::i2csr_state_t state;
	logic [7:0] shreg;
	logic [2:0] bit_cnt;
	logic bit_done, first_byte, read_mode, master_ack;
	logic [1:0] rd_sel;
	logic [31:0] hold_buf;
	logic rx_done, addr_hit, byte_rx;
	logic [6:0] my_addr;

	assign my_addr = {`I2CSR_ADDR_FIXED, strap_s};
	assign rx_done = (state == i2csr_pkg::I2CSR_RX) & scl_fall & bit_done;
	assign addr_hit = rx_done & first_byte & (shreg[7:1] == my_addr);
	assign byte_rx = rx_done & ~first_byte;

	// Bit and byte sequencing; START restarts from any state
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state <= i2csr_pkg::I2CSR_IDLE;
			shreg <= `I2CSR_ZERO_BYTE;
			bit_cnt <= `I2CSR_BIT_FIRST;
			bit_done <= 1'h0;
			first_byte <= 1'h0;
			read_mode <= 1'h0;
			master_ack <= 1'h0;
			rd_sel <= `I2CSR_RD_FIRST;
		end else if (bus_start) begin
			state <= i2csr_pkg::I2CSR_RX;
			first_byte <= 1'h1;
			bit_cnt <= `I2CSR_BIT_FIRST;
			bit_done <= 1'h0;
		end else if (bus_stop) begin
			state <= i2csr_pkg::I2CSR_IDLE;
		end else begin
			unique case (state)
				i2csr_pkg::I2CSR_IDLE: begin
					bit_done <= 1'h0;
				end
				i2csr_pkg::I2CSR_RX: begin
					if (scl_rise) begin
						shreg <= {shreg[6:0], sda_s};
						bit_cnt <= bit_cnt + 3'h1;
						bit_done <= (bit_cnt == `I2CSR_BIT_LAST);
					end else if (rx_done) begin
						bit_done <= 1'h0;
						first_byte <= 1'h0;
						if (first_byte & ~addr_hit) begin
							state <= i2csr_pkg::I2CSR_IDLE; // Not ours: wait for START
						end else begin
							state <= i2csr_pkg::I2CSR_ACK;
						end
						if (addr_hit) begin
							read_mode <= shreg[0];
							rd_sel <= `I2CSR_RD_FIRST;
						end
					end
				end
				i2csr_pkg::I2CSR_ACK: begin
					if (scl_fall) begin
						bit_cnt <= `I2CSR_BIT_FIRST;
						if (read_mode) begin
							shreg <= hold_buf[8 * rd_sel +: 8];
							rd_sel <= rd_sel - 2'h1;
							state <= i2csr_pkg::I2CSR_TX;
						end else begin
							state <= i2csr_pkg::I2CSR_RX;
						end
					end
				end
				i2csr_pkg::I2CSR_TX: begin
					if (scl_rise) begin
						bit_cnt <= bit_cnt + 3'h1;
						bit_done <= (bit_cnt == `I2CSR_BIT_LAST);
					end else if (scl_fall) begin
						if (bit_done) begin
							bit_done <= 1'h0;
							state <= i2csr_pkg::I2CSR_MACK;
						end else begin
							shreg <= {shreg[6:0], 1'h0};
						end
					end
				end
				i2csr_pkg::I2CSR_MACK: begin
					if (scl_rise) begin
						master_ack <= ~sda_s;
					end else if (scl_fall) begin
						bit_cnt <= `I2CSR_BIT_FIRST;
						if (master_ack) begin
							// Index wraps 0 to 3, so long reads repeat the word
							shreg <= hold_buf[8 * rd_sel +: 8];
							rd_sel <= rd_sel - 2'h1;
							state <= i2csr_pkg::I2CSR_TX;
						end else begin
							state <= i2csr_pkg::I2CSR_IDLE;
						end
					end
				end
			endcase
		end
	end

	// Open-drain drive, registered so the pin never glitches
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			sda_oe <= 1'h0;
		end else begin
			sda_oe <= (state == i2csr_pkg::I2CSR_ACK)
				| ((state == i2csr_pkg::I2CSR_TX) & ~shreg[7]);
		end
	end
	assign sda_drv = 1'h0;

	// ****************************************************************
	// Command and data capture
	// ****************************************************************
	logic [7:0] cmd_byte [0:2];
	logic [2:0] cmd_op;
	logic [31:0] wdata;
	logic [3:0] byte_idx;
	logic [31:0] next_wdata;
	i2csr_pkg::i2csr_req_t next_req;
	logic rd_pend, rd_valid;

	assign next_wdata = {wdata[23:0], shreg};

	// Command bytes fill first, then data; extra bytes are acked and dropped
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			byte_idx <= `I2CSR_IDX_FIRST;
			cmd_op <= 3'h0;
			wdata <= `I2CSR_ZERO_WORD;
			for (int i = 0; i < 3; i++) begin
				cmd_byte[i] <= `I2CSR_ZERO_BYTE;
			end
		end else if (addr_hit) begin
			byte_idx <= `I2CSR_IDX_FIRST;
		end else if (byte_rx && (byte_idx != `I2CSR_IDX_END)) begin
			byte_idx <= byte_idx + 4'h1;
			if (byte_idx == `I2CSR_IDX_FIRST) begin
				cmd_op <= shreg[`I2CSR_C0_OP];
			end else if (byte_idx <= `I2CSR_IDX_CMD_LAST) begin
				cmd_byte[byte_idx[1:0] - 2'h1] <= shreg;
			end else begin
				wdata <= next_wdata;
			end
		end
	end

	// Request fields: read on the last command byte, write on the last data byte
	always_comb begin
		if (byte_idx == `I2CSR_IDX_CMD_LAST) begin
			next_req = decode_cmd(cmd_byte[0], cmd_byte[1], shreg, `I2CSR_ZERO_WORD);
		end else begin
			next_req = decode_cmd(cmd_byte[0], cmd_byte[1], cmd_byte[2], next_wdata);
		end
		rd_valid = next_req.port < `I2CSR_NUM_PORTS;
	end

	// Issue one access; unknown ports are never issued
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			reg_req <= '0;
			reg_wr <= 1'h0;
			reg_rd <= 1'h0;
		end else begin
			reg_wr <= 1'h0;
			reg_rd <= 1'h0;
			if (byte_rx && rd_valid && (cmd_op == `I2CSR_OP_READ)
				&& (byte_idx == `I2CSR_IDX_CMD_LAST)) begin
				reg_req <= next_req;
				reg_rd <= 1'h1;
			end
			if (byte_rx && rd_valid && (cmd_op == `I2CSR_OP_WRITE)
				&& (byte_idx == `I2CSR_IDX_DATA_LAST)) begin
				reg_req <= next_req; // be gates each byte in the target
				reg_wr <= 1'h1;
			end
		end
	end

	// Holding buffer for the data phase; bad port reads back zero
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			rd_pend <= 1'h0;
			hold_buf <= `I2CSR_ZERO_WORD;
		end else begin
			rd_pend <= reg_rd;
			if (rd_pend) begin
				hold_buf <= reg_rdata;
			end else if (byte_rx && ~rd_valid && (cmd_op == `I2CSR_OP_READ)
				&& (byte_idx == `I2CSR_IDX_CMD_LAST)) begin
				hold_buf <= `I2CSR_ZERO_WORD;
			end
		end
	end

endmodule : i2csr_engine

// [testbench/i2csr_engine_monitor.sv]
/*
 * Port assertions for the register access engine.
 * Assumes binding to every engine instance; reset is synchronous.
 */
module i2csr_engine_monitor (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic scl_pin,
	input wire logic sda_drv,
	input wire logic sda_oe,
	input wire i2csr_pkg::i2csr_req_t reg_req,
	input wire logic reg_wr,
	input wire logic reg_rd
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	// Strobes last one cycle, so one packet is never applied twice
	property p_wr_pulse; reg_wr |=> !reg_wr; endproperty
	a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe too long");
	property p_rd_pulse; reg_rd |=> !reg_rd; endproperty
	a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe too long");
	property p_align; (reg_wr || reg_rd) |-> reg_req.addr[1:0] == 2'h0; endproperty
	a_align: assert property (p_align) else $error("unaligned access");
	property p_excl; !(reg_wr && reg_rd); endproperty
	a_excl: assert property (p_excl) else $error("read and write together");
	property p_port; (reg_wr || reg_rd) |-> reg_req.port < 5'h03; endproperty
	a_port: assert property (p_port) else $error("access to missing port");
	// Data only moves while scl is low, else it would read as START or STOP
	property p_oe_low; $changed(sda_oe) |-> !scl_pin; endproperty
	a_oe_low: assert property (p_oe_low) else $error("sda moved with scl high");
	property p_open; sda_drv == 1'b0; endproperty
	a_open: assert property (p_open) else $error("sda driven high");
	property p_hold; $changed(reg_req) |-> (reg_wr || reg_rd); endproperty
	a_hold: assert property (p_hold) else $error("request moved without access");
	c_wr: cover property (reg_wr);
	c_rd: cover property (reg_rd);
	c_ack: cover property ($rose(sda_oe));
endmodule : i2csr_engine_monitor

bind i2csr_engine i2csr_engine_monitor u_mon (.ref_clk(ref_clk), .reset(reset),
	.scl_pin(scl_pin), .sda_drv(sda_drv), .sda_oe(sda_oe), .reg_req(reg_req),
	.reg_wr(reg_wr), .reg_rd(reg_rd));

// [testbench/i2csr_master.sv]
/*
 * Bus master model: drives scl and pulls sda low.
 * Assumes the bench forms the wired sda with a pull-up.
 */
module i2csr_master (
	input wire logic ref_clk,
	input wire logic sda_w,
	output logic scl,
	output logic sda_low
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// Half a bus bit, well above the engine's sampling delay
	task automatic hp;
		repeat (12) @(posedge ref_clk);
	endtask : hp
	// START, or repeated START from scl low
	task automatic start;
		sda_low <= 1'b0;
		hp();
		scl <= 1'b1;
		hp();
		sda_low <= 1'b1;
		hp();
		scl <= 1'b0;
	endtask : start
	// STOP closes a packet, except where a repeated START follows the command
	task automatic stop;
		repeat (4) @(posedge ref_clk);
		sda_low <= 1'b1;
		hp();
		scl <= 1'b1;
		hp();
		sda_low <= 1'b0;
		hp();
	endtask : stop
	// Data moves a few cycles after scl falls, never on the fall itself
	task automatic bit_io(input logic b, output logic r);
		repeat (4) @(posedge ref_clk);
		sda_low <= !b;
		hp();
		scl <= 1'b1;
		hp();
		r = sda_w;
		scl <= 1'b0;
	endtask : bit_io
	// Byte out MSB first, returns the slave's ACK
	task automatic byte_out(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(b[i], r);
		end
		bit_io(1'b1, r);
		ack = !r;
	endtask : byte_out
	// Byte in, then ACK to go on or NACK to end
	task automatic byte_in(input logic ack, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			b[i] = r;
		end
		bit_io(!ack, r);
	endtask : byte_in
endmodule : i2csr_master

// [testbench/test_i2csr_engine.sv]
/*
 * Self-checking bench for the register access engine.
 * Assumes the master model and a pull-up on the wired sda.
 */
module test_i2csr_engine;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] RD_WORD = 32'ha1b2_c3d4;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic [2:0] addr_strap = 3'h0;
	logic [31:0] reg_rdata = 32'h0000_0000;
	wire logic scl, mst_low, sda_drv, sda_oe, reg_wr, reg_rd;
	wire i2csr_pkg::i2csr_req_t reg_req;
	wire logic sda = !(sda_oe || mst_low);
	int bad_count = 0;
	int checked = 0;
	int wr_seen = 0;
	int rd_seen = 0;
	always #25 ref_clk = ~ref_clk;
	// Config space stand-in: data valid only the cycle after the strobe
	always @(posedge ref_clk) begin
		if (reg_wr) wr_seen++;
		if (reg_rd) rd_seen++;
		reg_rdata <= reg_rd ? RD_WORD : 32'h0000_0000;
	end
	i2csr_engine u_dut (.ref_clk(ref_clk), .reset(reset), .scl_pin(scl), .sda_pin(sda),
		.sda_drv(sda_drv), .sda_oe(sda_oe), .addr_strap(addr_strap), .reg_req(reg_req),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	i2csr_master u_mst (.ref_clk(ref_clk), .sda_w(sda), .scl(scl), .sda_low(mst_low));
	task automatic finish_test;
		if (bad_count == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : finish_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic send(input logic [7:0] b, input logic exp_ack);
		logic a;
		u_mst.byte_out(b, a);
		chk({31'h0, a}, {31'h0, exp_ack});
	endtask : send
	task automatic cmd(input logic [7:0] c0, c1, c2, c3);
		u_mst.start();
		send(8'hd0, 1'b1);
		send(c0, 1'b1);
		send(c1, 1'b1);
		send(c2, 1'b1);
		send(c3, 1'b1);
	endtask : cmd
	task automatic wr_pkt(input logic [7:0] c0, c1, c2, c3, input logic [31:0] d);
		cmd(c0, c1, c2, c3);
		for (int i = 3; i >= 0; i--) send(d[8*i+:8], 1'b1);
		u_mst.stop();
	endtask : wr_pkt
	// Read phase, last byte NACKed; bytes wrap from the top byte
	task automatic rd_chk(input logic [31:0] exp, input int n);
		logic [7:0] b;
		send(8'hd1, 1'b1);
		for (int i = 0; i < n; i++) begin
			u_mst.byte_in(i < n - 1, b);
			chk({24'h0, b}, {24'h0, exp[31-8*(i%4)-:8]});
		end
		u_mst.stop();
	endtask : rd_chk
	task automatic test_write;
		int w = wr_seen;
		wr_pkt(8'h03, 8'h00, 8'h3c, 8'h3e, 32'h1234_5678);
		chk(32'(wr_seen - w), 32'h0000_0001);
		chk(32'(reg_req.port), 32'h0000_0000);
		chk(32'(reg_req.addr), 32'h0000_00f8);
		chk(32'(reg_req.be), 32'h0000_000f);
		chk(reg_req.wdata, 32'h1234_5678);
	endtask : test_write
	task automatic test_partial;
		int w = wr_seen;
		wr_pkt(8'h03, 8'h01, 8'h16, 8'h05, 32'haabb_ccdd);
		chk(32'(wr_seen - w), 32'h0000_0001);
		chk(32'(reg_req.port), 32'h0000_0002);
		chk(32'(reg_req.addr), 32'h0000_0814);
		chk(32'(reg_req.be), 32'h0000_0005);
		chk(reg_req.wdata, 32'haabb_ccdd);
	endtask : test_partial
	task automatic test_read;
		int r = rd_seen;
		cmd(8'h04, 8'h00, 8'hbc, 8'h3e);
		u_mst.start();
		rd_chk(RD_WORD, 5);
		chk(32'(rd_seen - r), 32'h0000_0001);
		chk(32'(reg_req.port), 32'h0000_0001);
		chk(32'(reg_req.addr), 32'h0000_00f8);
	endtask : test_read
	// Foreign address, unknown opcode and a missing port: no access at all
	task automatic test_refuse;
		int w = wr_seen;
		int r = rd_seen;
		u_mst.start();
		send(8'hd2, 1'b0);
		u_mst.stop();
		wr_pkt(8'h07, 8'h00, 8'h3c, 8'h3e, 32'h1111_2222);
		cmd(8'h04, 8'h01, 8'hbc, 8'h3e);
		u_mst.stop();
		u_mst.start();
		rd_chk(32'h0000_0000, 4);
		chk(32'(wr_seen - w), 32'h0000_0000);
		chk(32'(rd_seen - r), 32'h0000_0000);
	endtask : test_refuse
	initial begin
		repeat (20) @(posedge ref_clk);
		reset <= 1'b0;
		repeat (8) @(posedge ref_clk);
		test_write();
		test_partial();
		test_read();
		test_refuse();
		finish_test();
	end
	// Watchdog: the sequence needs about 13000 cycles
	initial begin
		repeat (40000) @(posedge ref_clk);
		bad_count++;
		finish_test();
	end
endmodule : test_i2csr_engine
